//--- stepper_param_command_port.sv
// Parameter store, pin control and motion command decoder for a stepper
//
// Contract
// - Eight direction bits, one selects output.
// - Enable bit6, resolution bits5..3, direction bit0.
// - Power-stage bits drive pins directly.
// - Output levels reach only output pins.
// - Duty value 0..249 sets PWM duty.
// - Duty above 249 gives full duty.
// - Command address write decodes motion action.
// - Ramped start: initial rate, accelerate to target.
// - Constant start: hold initial rate.
// - Starts stop after total step count.
// - Ramped stop decelerates to initial rate.
// - Speed change accelerates or decelerates toward target.
// - Seek rising home edge at initial rate.
// - Seek falling home edge at initial rate.
// - Commands load all stored motion parameters.
// - Rate is high byte shifted plus low.
// - Host writes are three-byte packets.
// - Step counts are 32-bit, MSB first.
// - Twenty-one byte addresses in parameter space.
`timescale 1ns/1ps
`default_nettype none
module stepper_param_command_port #(
  parameter logic [6:0] DEV_ADDR = 7'h2A // Arbitrary default target address
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Serial byte receiver
  input wire logic frame_start_i,
  input wire logic byte_valid_i,
  input wire logic [7:0] byte_i,
  // Stepping engine handshake
  input wire logic step_done_i,
  input wire logic ramp_tick_i,
  input wire logic home_sensor_i,
  // General-purpose pins
  input wire logic [7:0] gpio_i,
  output logic [7:0] gpio_o,
  output logic [7:0] gpio_oe_o,
  output logic [7:0] gpio_in_o,
  // Power stage pins
  output logic driver_enable_o,
  output logic [2:0] step_resolution_sel_o,
  output logic direction_o,
  output logic current_pwm_o,
  // Stepping engine controls
  output logic step_enable_o,
  output logic [15:0] step_rate_o,
  output logic [31:0] executed_steps_o
);
  param_wr_if wr ();
  logic [7:0] param_q [stepper_cmd_pkg::PARAM_BYTES]; // Stored motion bytes
  logic [7:0] duty_q; // Current PWM duty
  logic [7:0] pwm_cnt_q; // PWM period counter
  logic [31:0] total_q; // Loaded total step count
  logic [31:0] decel_at_q; // Loaded deceleration start step
  logic [15:0] init_rate_q; // Loaded initial step rate
  logic [15:0] target_q; // Loaded target step rate
  logic [15:0] up_rate_q; // Loaded acceleration rate
  logic [15:0] down_rate_q; // Loaded deceleration rate
  logic seek_rising_q; // Home edge polarity being sought
  logic home_q; // Previous home sensor level
  stepper_cmd_pkg::motion_state_t state_q;
  logic cmd_wr; // Motion command write this cycle
  logic home_hit; // Sought home edge seen
  logic last_step; // Step just done is the final one

  ////////////////////////////////////////////////////////////
  // Byte pair to rate
  function automatic logic [15:0] pair16(input logic [7:0] hi, input logic [7:0] lo);
    pair16 = {hi, 8'h00} + {8'h00, lo};
  endfunction

  // Four bytes to count, most significant first
  function automatic logic [31:0] quad32(input logic [7:0] b3, input logic [7:0] b2,
                                         input logic [7:0] b1, input logic [7:0] b0);
    quad32 = {pair16(b3, b2), pair16(b1, b0)};
  endfunction

  // One ramp step toward a limit, never passing it
  function automatic logic [15:0] ramp(input logic [15:0] cur, input logic [15:0] dlt,
                                       input logic [15:0] lim, input logic up);
    logic [16:0] sum;
    sum = {1'b0, cur} + {1'b0, dlt};
    if (up) begin
      ramp = (sum >= {1'b0, lim}) ? lim : sum[15:0];
    end else begin
      ramp = ({1'b0, cur} <= {1'b0, lim} + {1'b0, dlt}) ? lim : cur - dlt;
    end
  endfunction

  ////////////////////////////////////////////////////////////
  // Packet assembly
  param_packet_rx #(.DEV_ADDR(DEV_ADDR)) u_rx (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .frame_start_i(frame_start_i),
    .byte_valid_i(byte_valid_i),
    .byte_i(byte_i),
    .wr(wr.rx)
  );

  assign cmd_wr = wr.wr_valid && wr.wr_addr == stepper_cmd_pkg::ADDR_MOTION_COMMAND;
  assign home_hit = (state_q == stepper_cmd_pkg::MS_HOME) &&
                    (seek_rising_q ? (home_sensor_i && !home_q)
                                   : (!home_sensor_i && home_q));
  assign last_step = step_done_i && (executed_steps_o + 32'h1 == total_q);

  ////////////////////////////////////////////////////////////
  // Motion parameter bytes; addresses past the table are ignored
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < stepper_cmd_pkg::PARAM_BYTES; i++) begin
        param_q[i] <= stepper_cmd_pkg::RESET_BYTE;
      end
    end else if (wr.wr_valid && wr.wr_addr < stepper_cmd_pkg::ADDR_GPIO_DIRECTION) begin
      param_q[wr.wr_addr[3:0]] <= wr.wr_data;
    end
  end

  // GPIO direction and levels; pins set as inputs are never driven
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gpio_oe_o <= stepper_cmd_pkg::RESET_BYTE;
      gpio_o <= stepper_cmd_pkg::RESET_BYTE;
    end else if (wr.wr_valid) begin
      if (wr.wr_addr == stepper_cmd_pkg::ADDR_GPIO_DIRECTION) begin
        gpio_oe_o <= wr.wr_data;
      end
      if (wr.wr_addr == stepper_cmd_pkg::ADDR_GPIO_OUTPUT_LEVELS) begin
        gpio_o <= wr.wr_data;
      end
    end
  end

  // Pin levels as seen, registered for the engine side
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gpio_in_o <= stepper_cmd_pkg::RESET_BYTE;
    end else begin
      gpio_in_o <= gpio_i;
    end
  end

  // Power stage pins follow the written byte at once; unused bits dropped
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      driver_enable_o <= 1'b0;
      step_resolution_sel_o <= 3'h0;
      direction_o <= 1'b0;
    end else if (wr.wr_valid && wr.wr_addr == stepper_cmd_pkg::ADDR_POWER_STAGE_CONTROL) begin
      driver_enable_o <= wr.wr_data[stepper_cmd_pkg::PSC_ENABLE_BIT];
      step_resolution_sel_o <=
        wr.wr_data[stepper_cmd_pkg::PSC_RES_MSB:stepper_cmd_pkg::PSC_RES_LSB];
      direction_o <= wr.wr_data[stepper_cmd_pkg::PSC_DIR_BIT];
    end
  end

  ////////////////////////////////////////////////////////////
  // Duty register; no range check on purpose
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      duty_q <= stepper_cmd_pkg::RESET_BYTE;
    end else if (wr.wr_valid && wr.wr_addr == stepper_cmd_pkg::ADDR_CURRENT_PWM_DUTY) begin
      duty_q <= wr.wr_data;
    end
  end

  // 250-count period; counter never exceeds 249 so larger duty stays high
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pwm_cnt_q <= stepper_cmd_pkg::RESET_BYTE;
      current_pwm_o <= 1'b0;
    end else begin
      pwm_cnt_q <= (pwm_cnt_q == stepper_cmd_pkg::PWM_LAST_COUNT) ? 8'h00 : pwm_cnt_q + 8'h01;
      current_pwm_o <= pwm_cnt_q < duty_q;
    end
  end

  ////////////////////////////////////////////////////////////
  // Every command reloads the engine parameters from the byte table
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      total_q <= 32'h0000_0000;
      decel_at_q <= 32'h0000_0000;
      init_rate_q <= 16'h0000;
      target_q <= 16'h0000;
      up_rate_q <= 16'h0000;
      down_rate_q <= 16'h0000;
    end else if (cmd_wr) begin
      total_q <= quad32(param_q[0], param_q[1], param_q[2], param_q[3]);
      decel_at_q <= quad32(param_q[4], param_q[5], param_q[6], param_q[7]);
      init_rate_q <= pair16(param_q[8], param_q[9]);
      up_rate_q <= pair16(param_q[10], param_q[11]);
      target_q <= pair16(param_q[12], param_q[13]);
      down_rate_q <= pair16(param_q[14], param_q[15]);
    end
  end

  // Home sensor history for edge detection
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      home_q <= 1'b0;
    end else begin
      home_q <= home_sensor_i;
    end
  end

  // Executed step counter; every command except ramp stop and speed change clears it
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      executed_steps_o <= 32'h0000_0000;
    end else if (cmd_wr && wr.wr_data != stepper_cmd_pkg::CMD_RAMP_STOP &&
                 wr.wr_data != stepper_cmd_pkg::CMD_SPEED_CHANGE) begin
      executed_steps_o <= 32'h0000_0000;
    end else if (step_done_i && step_enable_o) begin
      executed_steps_o <= executed_steps_o + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////
  // Motion sequencer; a command outranks a step or ramp tick in the same cycle
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= stepper_cmd_pkg::MS_IDLE;
      step_rate_o <= 16'h0000;
      seek_rising_q <= 1'b0;
    end else if (cmd_wr) begin
      unique case (wr.wr_data)
        stepper_cmd_pkg::CMD_RAMP_START: begin
          state_q <= stepper_cmd_pkg::MS_ACCEL;
          step_rate_o <= pair16(param_q[8], param_q[9]);
        end
        stepper_cmd_pkg::CMD_CONST_START: begin
          state_q <= stepper_cmd_pkg::MS_CONST;
          step_rate_o <= pair16(param_q[8], param_q[9]);
        end
        stepper_cmd_pkg::CMD_RAMP_STOP: begin
          // Stopping an idle motor does nothing
          if (state_q != stepper_cmd_pkg::MS_IDLE) begin
            state_q <= stepper_cmd_pkg::MS_STOP;
          end
        end
        stepper_cmd_pkg::CMD_SPEED_CHANGE: begin
          // Only meaningful while running
          if (state_q != stepper_cmd_pkg::MS_IDLE) begin
            state_q <= (pair16(param_q[12], param_q[13]) >= step_rate_o) ?
                       stepper_cmd_pkg::MS_ACCEL : stepper_cmd_pkg::MS_DECEL;
          end
        end
        stepper_cmd_pkg::CMD_SEEK_REF_RISING,
        stepper_cmd_pkg::CMD_SEEK_REF_FALLING: begin
          state_q <= stepper_cmd_pkg::MS_HOME;
          step_rate_o <= pair16(param_q[8], param_q[9]);
          seek_rising_q <= wr.wr_data == stepper_cmd_pkg::CMD_SEEK_REF_RISING;
        end
        default: begin
          // Unknown opcode: no action
        end
      endcase
    end else if (state_q != stepper_cmd_pkg::MS_IDLE && (last_step || home_hit)) begin
      state_q <= stepper_cmd_pkg::MS_IDLE;
    end else if (step_done_i && executed_steps_o + 32'h1 == decel_at_q &&
                 state_q != stepper_cmd_pkg::MS_IDLE && state_q != stepper_cmd_pkg::MS_HOME) begin
      state_q <= stepper_cmd_pkg::MS_STOP; // Planned deceleration point
    end else if (ramp_tick_i) begin
      unique case (state_q)
        stepper_cmd_pkg::MS_ACCEL: begin
          step_rate_o <= ramp(step_rate_o, up_rate_q, target_q, 1'b1);
          if (ramp(step_rate_o, up_rate_q, target_q, 1'b1) == target_q) begin
            state_q <= stepper_cmd_pkg::MS_CONST;
          end
        end
        stepper_cmd_pkg::MS_DECEL: begin
          step_rate_o <= ramp(step_rate_o, down_rate_q, target_q, 1'b0);
          if (ramp(step_rate_o, down_rate_q, target_q, 1'b0) == target_q) begin
            state_q <= stepper_cmd_pkg::MS_CONST;
          end
        end
        stepper_cmd_pkg::MS_STOP: begin
          step_rate_o <= ramp(step_rate_o, down_rate_q, init_rate_q, 1'b0);
          if (ramp(step_rate_o, down_rate_q, init_rate_q, 1'b0) == init_rate_q) begin
            state_q <= stepper_cmd_pkg::MS_IDLE;
          end
        end
        default: begin
          // Idle, constant and homing hold the rate
        end
      endcase
    end
  end

  // Engine runs in every state but idle
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      step_enable_o <= 1'b0;
    end else begin
      step_enable_o <= 1'b0;
      unique case (1'b1)
        cmd_wr: step_enable_o <= step_enable_o ||
                                 wr.wr_data == stepper_cmd_pkg::CMD_RAMP_START ||
                                 wr.wr_data == stepper_cmd_pkg::CMD_CONST_START ||
                                 wr.wr_data == stepper_cmd_pkg::CMD_SEEK_REF_RISING ||
                                 wr.wr_data == stepper_cmd_pkg::CMD_SEEK_REF_FALLING;
        default: step_enable_o <= state_q != stepper_cmd_pkg::MS_IDLE && !last_step &&
                                  !home_hit;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////
  // Checks
  sequence s_cmd(logic [7:0] op);
    cmd_wr && wr.wr_data == op;
  endsequence
  a_gpio_dir_wr: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    wr.wr_valid && wr.wr_addr == stepper_cmd_pkg::ADDR_GPIO_DIRECTION
    |=> gpio_oe_o == $past(wr.wr_data))
    else $error("direction write not applied");
  a_power_pins: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    wr.wr_valid && wr.wr_addr == stepper_cmd_pkg::ADDR_POWER_STAGE_CONTROL
    |=> driver_enable_o == $past(wr.wr_data[6]) && step_resolution_sel_o ==
        $past(wr.wr_data[5:3]) && direction_o == $past(wr.wr_data[0]))
    else $error("power stage pins not updated");
  a_pwm_full_duty: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    duty_q > stepper_cmd_pkg::PWM_LAST_COUNT && $stable(duty_q) |=> current_pwm_o)
    else $error("duty above 249 not full");
  a_pwm_zero_duty: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    duty_q == 8'h00 && $stable(duty_q) |=> !current_pwm_o)
    else $error("zero duty drove PWM high");
  a_ramp_start_rate: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    s_cmd(stepper_cmd_pkg::CMD_RAMP_START) |=> state_q == stepper_cmd_pkg::MS_ACCEL &&
    step_rate_o == init_rate_q && executed_steps_o == 32'h0)
    else $error("ramped start wrong");
  a_const_hold: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    s_cmd(stepper_cmd_pkg::CMD_CONST_START) ##1 ramp_tick_i && !cmd_wr && !step_done_i
    |=> step_rate_o == $past(step_rate_o))
    else $error("constant run changed rate");
  a_total_stops: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    state_q != stepper_cmd_pkg::MS_IDLE && last_step && !cmd_wr
    |=> state_q == stepper_cmd_pkg::MS_IDLE && !step_enable_o)
    else $error("did not stop at total count");
  a_speed_change: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    s_cmd(stepper_cmd_pkg::CMD_SPEED_CHANGE) && state_q != stepper_cmd_pkg::MS_IDLE &&
    pair16(param_q[12], param_q[13]) < step_rate_o
    |=> state_q == stepper_cmd_pkg::MS_DECEL)
    else $error("speed change direction wrong");
  a_home_stop: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    home_hit && !cmd_wr |=> state_q == stepper_cmd_pkg::MS_IDLE ##1 !step_enable_o)
    else $error("home edge did not stop motor");
endmodule
`default_nettype wire

//--- stepper_cmd_pkg.sv
// Constants and types shared by the stepper parameter/command port
package stepper_cmd_pkg;
  // Parameter byte addresses
  localparam logic [7:0] ADDR_TOTAL_STEPS3 = 8'h00;
  localparam logic [7:0] ADDR_TOTAL_STEPS2 = 8'h01;
  localparam logic [7:0] ADDR_TOTAL_STEPS1 = 8'h02;
  localparam logic [7:0] ADDR_TOTAL_STEPS0 = 8'h03;
  localparam logic [7:0] ADDR_DECEL_BEGIN3 = 8'h04;
  localparam logic [7:0] ADDR_DECEL_BEGIN2 = 8'h05;
  localparam logic [7:0] ADDR_DECEL_BEGIN1 = 8'h06;
  localparam logic [7:0] ADDR_DECEL_BEGIN0 = 8'h07;
  localparam logic [7:0] ADDR_INIT_RATE1 = 8'h08;
  localparam logic [7:0] ADDR_INIT_RATE0 = 8'h09;
  localparam logic [7:0] ADDR_RAMP_UP1 = 8'h0A;
  localparam logic [7:0] ADDR_RAMP_UP0 = 8'h0B;
  localparam logic [7:0] ADDR_TARGET_RATE1 = 8'h0C;
  localparam logic [7:0] ADDR_TARGET_RATE0 = 8'h0D;
  localparam logic [7:0] ADDR_RAMP_DOWN1 = 8'h0E;
  localparam logic [7:0] ADDR_RAMP_DOWN0 = 8'h0F;
  localparam logic [7:0] ADDR_GPIO_DIRECTION = 8'h10;
  localparam logic [7:0] ADDR_POWER_STAGE_CONTROL = 8'h11;
  localparam logic [7:0] ADDR_GPIO_OUTPUT_LEVELS = 8'h12;
  localparam logic [7:0] ADDR_CURRENT_PWM_DUTY = 8'h13;
  localparam logic [7:0] ADDR_MOTION_COMMAND = 8'h14;
  localparam int PARAM_BYTES = 16;
  // Power stage control field positions
  localparam int PSC_ENABLE_BIT = 6;
  localparam int PSC_RES_MSB = 5;
  localparam int PSC_RES_LSB = 3;
  localparam int PSC_DIR_BIT = 0;
  // Motion command opcodes
  localparam logic [7:0] CMD_RAMP_START = 8'h00;
  localparam logic [7:0] CMD_CONST_START = 8'h01;
  localparam logic [7:0] CMD_RAMP_STOP = 8'h02;
  localparam logic [7:0] CMD_SPEED_CHANGE = 8'h03;
  localparam logic [7:0] CMD_SEEK_REF_RISING = 8'h04;
  localparam logic [7:0] CMD_SEEK_REF_FALLING = 8'h05;
  // Current PWM: counter runs 0..249
  localparam logic [7:0] PWM_LAST_COUNT = 8'hF9;
  // Reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Packet byte positions
  localparam logic [1:0] PKT_DEV_BYTE = 2'h0;
  localparam logic [1:0] PKT_ADDR_BYTE = 2'h1;
  localparam logic [1:0] PKT_DATA_BYTE = 2'h2;
  // Motion sequencer states
  typedef enum logic [2:0] {
    MS_IDLE, MS_ACCEL, MS_CONST, MS_DECEL, MS_STOP, MS_HOME
  } motion_state_t;
endpackage

//--- param_wr_if.sv
// Write-strobe carrier between packet receiver and parameter core
`timescale 1ns/1ps
`default_nettype none
interface param_wr_if;
  logic wr_valid; // One-cycle write strobe
  logic [7:0] wr_addr; // Parameter address
  logic [7:0] wr_data; // Data byte
  modport rx (output wr_valid, output wr_addr, output wr_data);
  modport core (input wr_valid, input wr_addr, input wr_data);
endinterface
`default_nettype wire

//--- param_packet_rx.sv
// Three-byte write packet assembler fed by the serial byte receiver
`timescale 1ns/1ps
`default_nettype none
module param_packet_rx #(
  parameter logic [6:0] DEV_ADDR = 7'h2A // Arbitrary default target address
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Received byte stream
  input wire logic frame_start_i,
  input wire logic byte_valid_i,
  input wire logic [7:0] byte_i,
  // Assembled write
  param_wr_if.rx wr
);
  logic [1:0] pos_q; // Byte position within packet
  logic match_q; // Target address matched
  logic [7:0] addr_q; // Held register address

  ////////////////////////////////////////////////////////////
  // Byte position; a new frame always restarts at the device byte
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pos_q <= stepper_cmd_pkg::PKT_DEV_BYTE;
    end else if (frame_start_i) begin
      pos_q <= stepper_cmd_pkg::PKT_DEV_BYTE;
    end else if (byte_valid_i && pos_q != 2'h3) begin
      pos_q <= pos_q + 2'h1;
    end
  end

  // Target match: write bit must be low
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      match_q <= 1'b0;
    end else if (frame_start_i) begin
      match_q <= 1'b0;
    end else if (byte_valid_i && pos_q == stepper_cmd_pkg::PKT_DEV_BYTE) begin
      match_q <= (byte_i[7:1] == DEV_ADDR) && !byte_i[0];
    end
  end

  // Register address capture
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      addr_q <= stepper_cmd_pkg::RESET_BYTE;
    end else if (byte_valid_i && pos_q == stepper_cmd_pkg::PKT_ADDR_BYTE) begin
      addr_q <= byte_i;
    end
  end

  // Third byte completes the packet; extra bytes are dropped
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr.wr_valid <= 1'b0;
      wr.wr_addr <= stepper_cmd_pkg::RESET_BYTE;
      wr.wr_data <= stepper_cmd_pkg::RESET_BYTE;
    end else begin
      wr.wr_valid <= byte_valid_i && !frame_start_i && match_q &&
                     pos_q == stepper_cmd_pkg::PKT_DATA_BYTE;
      if (byte_valid_i && pos_q == stepper_cmd_pkg::PKT_DATA_BYTE) begin
        wr.wr_addr <= addr_q;
        wr.wr_data <= byte_i;
      end
    end
  end

  // A strobe is only ever the third byte of a matched packet
  sequence s_data_byte;
    byte_valid_i && !frame_start_i && match_q &&
    pos_q == stepper_cmd_pkg::PKT_DATA_BYTE;
  endsequence
  a_pkt_third_byte: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    wr.wr_valid |-> $past(pos_q) == stepper_cmd_pkg::PKT_DATA_BYTE)
    else $error("write strobe not from third packet byte");
  a_pkt_strobe_out: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    s_data_byte |=> wr.wr_valid && wr.wr_data == $past(byte_i))
    else $error("matched data byte produced no write");
endmodule
`default_nettype wire

//--- stepper_host_model.sv
// Host model that sends three-byte parameter write packets
`timescale 1ns/1ps
`default_nettype none
module stepper_host_model (
  // Clock
  input wire logic clk_sys_i,
  // Byte stream towards the port
  output logic frame_start_o,
  output logic byte_valid_o,
  output logic [7:0] byte_o
);
  // Idle lines; data shows junk between packets
  initial begin
    frame_start_o = 1'b0;
    byte_valid_o = 1'b0;
    byte_o = 8'h00;
  end
  // Frame start, then device, address and data bytes back to back
  task automatic send(input logic [7:0] dev, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] b [3];
    b = '{dev, a, d};
    @(posedge clk_sys_i);
    frame_start_o <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys_i);
      frame_start_o <= 1'b0;
      byte_valid_o <= 1'b1;
      byte_o <= b[i];
    end
    @(posedge clk_sys_i);
    byte_valid_o <= 1'b0;
    byte_o <= ~b[2];
  endtask
endmodule
`default_nettype wire

//--- stepper_param_command_port_test.sv
// Self-checking bench for the stepper parameter and command port
`timescale 1ns/1ps
`default_nettype none
module stepper_param_command_port_test;
  localparam logic [7:0] DEV = 8'h54; // Device byte, write bit clear
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic step_done_i = 1'b0;
  logic ramp_tick_i = 1'b0;
  logic home_sensor_i = 1'b0;
  logic [7:0] gpio_i = 8'h5A;
  logic frame_start_i, byte_valid_i, driver_enable_o, direction_o, current_pwm_o, step_enable_o;
  logic [7:0] byte_i, gpio_o, gpio_oe_o, gpio_in_o;
  logic [2:0] step_resolution_sel_o;
  logic [15:0] step_rate_o;
  logic [31:0] executed_steps_o;
  logic [63:0] hi;
  int n_fail = 0;
  int checks = 0;
  // Rows: device, address, data, expected {oe, driven levels, en, res, dir}
  localparam logic [44:0] ROWS [7] = '{
    {DEV, 8'h10, 8'hF0, 8'hF0, 8'h00, 5'h00}, {DEV, 8'h12, 8'hFF, 8'hF0, 8'hF0, 5'h00},
    {DEV, 8'h11, 8'hFF, 8'hF0, 8'hF0, 5'h1F}, {DEV, 8'h11, 8'h41, 8'hF0, 8'hF0, 5'h11},
    {8'h00, 8'h10, 8'h0F, 8'hF0, 8'hF0, 5'h11}, {DEV, 8'h15, 8'h00, 8'hF0, 8'hF0, 5'h11},
    {DEV, 8'h10, 8'h0F, 8'h0F, 8'h0F, 5'h11}};
  localparam logic [15:0] DUTY [4] = '{16'h0000, 16'h7D7D, 16'hF9F9, 16'hFFFA};
  // Counts 5 and 0, initial 0102, up 0010, target 0122, down 0010
  localparam logic [127:0] PRM = 128'h00000005_00000000_0102_0010_0122_0010;
  always #4 clk_sys_i = ~clk_sys_i;
  stepper_host_model u_host (.clk_sys_i, .frame_start_o(frame_start_i),
    .byte_valid_o(byte_valid_i), .byte_o(byte_i));
  stepper_param_command_port u_dut (.clk_sys_i, .reset_n_i, .frame_start_i, .byte_valid_i,
    .byte_i, .step_done_i, .ramp_tick_i, .home_sensor_i, .gpio_i, .gpio_o, .gpio_oe_o,
    .gpio_in_o, .driver_enable_o, .step_resolution_sel_o, .direction_o, .current_pwm_o,
    .step_enable_o, .step_rate_o, .executed_steps_o);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Wait edges, then step past them so outputs are settled
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.send(DEV, a, d);
    settle(1);
  endtask
  // One-cycle engine pulse: ramp tick when tick is set, else a done step
  task automatic pulse(input bit tick);
    @(posedge clk_sys_i);
    if (tick) begin
      ramp_tick_i <= 1'b1;
    end else begin
      step_done_i <= 1'b1;
    end
    @(posedge clk_sys_i);
    ramp_tick_i <= 1'b0;
    step_done_i <= 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Watchdog: the whole run needs well under this
  initial begin
    #400000;
    n_fail++;
    tally_and_finish();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    settle(5);
    chk({gpio_oe_o, gpio_o, driver_enable_o, step_enable_o}, 64'h0);
    @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    foreach (ROWS[i]) begin
      u_host.send(ROWS[i][44:37], ROWS[i][36:29], ROWS[i][28:21]);
      settle(1);
      chk({gpio_oe_o, gpio_o & gpio_oe_o, driver_enable_o, step_resolution_sel_o,
        direction_o}, ROWS[i][20:0]);
    end
    chk(gpio_in_o, 8'h5A);
    // Duty sweep, including an out-of-range value
    foreach (DUTY[i]) begin
      wr(8'h13, DUTY[i][15:8]);
      hi = 64'h0;
      settle(3);
      repeat (250) begin
        settle(1);
        hi = hi + current_pwm_o;
      end
      chk(hi, DUTY[i][7:0]);
    end
    for (int i = 0; i < 16; i++) wr(i[7:0], PRM[127 - 8 * i -: 8]);
    wr(8'h14, 8'h01);
    chk({step_enable_o, step_rate_o, executed_steps_o},
      {1'b1, 48'h0102_0000_0000});
    pulse(1'b1);
    repeat (4) pulse(1'b0);
    settle(1);
    chk({step_enable_o, step_rate_o, executed_steps_o},
      {1'b1, 48'h0102_0000_0004});
    pulse(1'b0);
    settle(2);
    chk(step_enable_o, 1'b0);
    wr(8'h14, 8'h00);
    chk({step_enable_o, step_rate_o, executed_steps_o},
      {1'b1, 48'h0102_0000_0000});
    repeat (3) pulse(1'b1);
    settle(1);
    chk(step_rate_o, 16'h0122);
    wr(8'h0D, 8'h05);
    wr(8'h14, 8'h03);
    pulse(1'b1);
    settle(1);
    chk(step_rate_o, 16'h0112);
    wr(8'h14, 8'h02);
    repeat (2) pulse(1'b1);
    settle(2);
    chk({step_enable_o, step_rate_o}, 17'h00102);
    wr(8'h14, 8'h06);
    chk(step_enable_o, 1'b0);
    wr(8'h14, 8'h04);
    chk(step_enable_o, 1'b1);
    @(posedge clk_sys_i);
    home_sensor_i <= 1'b1;
    settle(3);
    chk(step_enable_o, 1'b0);
    wr(8'h14, 8'h05);
    chk(step_enable_o, 1'b1);
    @(posedge clk_sys_i);
    home_sensor_i <= 1'b0;
    settle(3);
    chk(step_enable_o, 1'b0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
